// ==== dv/fod_sdo_client.sv ====
// Behavioural service-data client that issues dictionary requests one at a time.
// Assumes the bench calls xfer only after reset has been released for three edges.
`timescale 1ns/1ps
`default_nettype none
module fod_sdo_client
   import fod_pkg::*;
(
   input wire logic clk,
   input wire logic rsp_valid,
   input wire fod_rsp_t rsp_kind,
   input wire logic [31:0] rsp_data,
   output logic req_valid,
   output logic req_write,
   output logic [15:0] req_index,
   output logic [7:0] req_subindex,
   output logic [2:0] req_size,
   output logic [31:0] req_data
);
   // Idle port at time zero
   initial
   begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_index = 16'h0000;
      req_subindex = 8'h00;
      req_size = 3'h0;
      req_data = 32'h0000_0000;
   end

   // One transfer; released qualifiers other than size show inverted values so stale data never looks valid
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [2:0] sz,
      input logic [31:0] wd, output fod_rsp_t kind, output logic [31:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_index <= idx;
      req_subindex <= sub;
      req_size <= sz;
      req_data <= wd;
      @(posedge clk);
      req_valid <= 1'b0;
      req_write <= ~wr;
      req_index <= ~idx;
      req_subindex <= ~sub;
      req_data <= ~wd;
      for (n = 0; n < 8 && !ok; n++)
      begin
         @(negedge clk);
         if (rsp_valid === 1'b1)
         begin
            ok = 1'b1;
            kind = rsp_kind;
            rd = rsp_data;
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the fieldbus object dictionary.
// Assumes the client model drives the request port and the bench drives the measurement inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import fod_pkg::*;
;
   localparam int MEAS = 20;
   logic clk, resetn, req_valid, req_write, rsp_valid, flow_invalid, class_format;
   logic [15:0] req_index, class_4um, class_6um, class_14um, volume_flow, record_count_in;
   logic [7:0] req_subindex, limit_4um_out, limit_6um_out, limit_14um_out;
   logic [2:0] req_size;
   logic [31:0] req_data, rsp_data, float_4um, float_6um, float_14um, float_flow, record_word, time_id_out;
   logic records_clear, save_request, measure_done, pdo_send, emcy_send;
   logic [15:0] storage_interval_out, heartbeat_out;
   logic [63:0] pdo_payload, emcy_payload, last_pdo, last_emcy;
   fod_rsp_t rsp_kind;
   int miscompares = 0;
   int num_checks = 0;
   int n_save = 0, n_clr = 0, n_emcy = 0, n_done = 0, n_pdo = 0;

   fod_dictionary #(.MEAS_CYCLES(MEAS)) fod_dictionary_i (.clk(clk), .resetn(resetn), .req_valid(req_valid),
      .req_write(req_write), .req_index(req_index), .req_subindex(req_subindex), .req_size(req_size),
      .req_data(req_data), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_data(rsp_data),
      .class_4um(class_4um), .class_6um(class_6um), .class_14um(class_14um), .volume_flow(volume_flow),
      .float_4um(float_4um), .float_6um(float_6um), .float_14um(float_14um), .float_flow(float_flow),
      .flow_invalid(flow_invalid), .class_format(class_format), .record_count_in(record_count_in),
      .record_word(record_word), .records_clear(records_clear), .save_request(save_request),
      .limit_4um_out(limit_4um_out), .limit_6um_out(limit_6um_out), .limit_14um_out(limit_14um_out),
      .storage_interval_out(storage_interval_out), .time_id_out(time_id_out), .heartbeat_out(heartbeat_out),
      .measure_done(measure_done), .pdo_send(pdo_send), .pdo_payload(pdo_payload), .emcy_send(emcy_send),
      .emcy_payload(emcy_payload));

   fod_sdo_client fod_sdo_client_i (.clk(clk), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_data(rsp_data),
      .req_valid(req_valid), .req_write(req_write), .req_index(req_index), .req_subindex(req_subindex),
      .req_size(req_size), .req_data(req_data));

   // Clock at 50 ns period
   always #25 clk = ~clk;

   // Pulse counters sampled mid-cycle, so pulse timing never races the checks
   always @(negedge clk)
   begin
      if (save_request === 1'b1) n_save++;
      if (records_clear === 1'b1) n_clr++;
      if (measure_done === 1'b1) n_done++;
      if (emcy_send === 1'b1)
      begin
         n_emcy++;
         last_emcy = emcy_payload;
      end
      if (pdo_send === 1'b1)
      begin
         n_pdo++;
         last_pdo = pdo_payload;
      end
   end

   task automatic print_verdict;
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One access with its expected answer; a missing answer ends the run
   task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [2:0] sz,
      input logic [31:0] wd, input fod_rsp_t ek, input logic [31:0] ed);
      fod_rsp_t k;
      logic [31:0] d;
      logic ok;
      fod_sdo_client_i.xfer(wr, idx, sub, sz, wd, k, d, ok);
      // Let pulse counters and registered copies settle; resume on a rising edge
      repeat (2) @(posedge clk);
      if (!ok)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         print_verdict();
      end
      chk({k, d}, {ek, ed});
   endtask

   task automatic t_regs;
      int i;
      acc(0, 16'h3003, 0, 2, 0, FOD_RSP_READ, 32'h0000_0001);
      acc(0, 16'h1010, 1, 4, 0, FOD_RSP_READ, 32'h0000_0001);
      acc(0, 16'h1001, 0, 1, 0, FOD_RSP_READ, 32'h0000_0000);
      acc(0, 16'h1002, 0, 4, 0, FOD_RSP_READ, 32'h0000_0000);
      acc(1, 16'h1002, 0, 4, 32'h0000_00F0, FOD_RSP_ABORT, 32'h0601_0002);
      acc(0, 16'h2000, 0, 4, 0, FOD_RSP_ABORT, 32'h0602_0000);
      acc(0, 16'h5000, 0, 1, 0, FOD_RSP_READ, 32'h0000_0004);
      // Subentries 1 to 4 in class then flow order
      for (i = 1; i < 5; i++)
         acc(0, 16'h5000, 8'(i), 2, 0, FOD_RSP_READ, {16'h0000, 16'h0010 + 16'(i)});
      acc(0, 16'h5100, 1, 4, 0, FOD_RSP_READ, float_4um);
      acc(0, 16'h4001, 0, 2, 0, FOD_RSP_READ, 32'h0000_0003);
      acc(1, 16'h4001, 0, 2, 32'h0000_0005, FOD_RSP_ABORT, 32'h0601_0002);
      acc(1, 16'h4001, 0, 2, 0, FOD_RSP_WRITE, 0);
      chk(n_clr, 1);
      acc(0, 16'h4005, 1, 1, 0, FOD_RSP_ABORT, 32'h0601_0000);
      acc(0, 16'h1014, 0, 4, 0, FOD_RSP_READ, 32'h0000_0081);
      acc(0, 16'h1A00, 2, 4, 0, FOD_RSP_READ, 32'h5000_0210);
      acc(1, 16'h1017, 0, 2, 32'h0000_0032, FOD_RSP_WRITE, 0);
      acc(1, 16'h4000, 0, 2, 32'h0000_0018, FOD_RSP_WRITE, 0);
      chk({heartbeat_out, storage_interval_out}, 32'h0032_0018);
   endtask

   task automatic t_save;
      acc(1, 16'h1010, 1, 4, {8'h65, 8'h76, 8'h61, 8'h74}, FOD_RSP_ABORT, 32'h0601_0002);
      chk(n_save, 0);
      acc(1, 16'h1010, 1, 4, {8'h65, 8'h76, 8'h61, 8'h73}, FOD_RSP_WRITE, 0);
      chk(n_save, 1);
   endtask

   task automatic t_limits;
      int i;
      int e0;
      class_format <= 1'b1;
      class_4um <= 16'h0006;
      acc(1, 16'h3000, 0, 1, 32'h0000_0006, FOD_RSP_WRITE, 0);
      chk(limit_4um_out, 8'h06);
      acc(0, 16'h1002, 0, 4, 0, FOD_RSP_READ, 0);
      acc(1, 16'h3000, 0, 1, 0, FOD_RSP_WRITE, 0);
      class_4um <= 16'h0007;
      class_6um <= 16'h0007;
      class_14um <= 16'h0007;
      // Each channel in turn: 4, 6 then 14 micron limits
      for (i = 0; i < 3; i++)
      begin
         e0 = n_emcy;
         acc(1, 16'h3000 + 16'(i), 0, 1, 32'h0000_0006, FOD_RSP_WRITE, 0);
         chk({limit_14um_out, limit_6um_out, limit_4um_out}, 24'h00_0006 << (8 * i));
         repeat (3) @(posedge clk);
         acc(0, 16'h1002, 0, 4, 0, FOD_RSP_READ, 32'h8 >> i);
         acc(0, 16'h1001, 0, 1, 0, FOD_RSP_READ, 32'h0000_0001);
         chk(n_emcy, e0 + 1);
         chk(last_emcy, {8'h00, 32'h8 >> i, 8'h01, 16'hFF00});
         acc(1, 16'h3000 + 16'(i), 0, 1, 0, FOD_RSP_WRITE, 0);
         acc(0, 16'h1001, 0, 1, 0, FOD_RSP_READ, 0);
      end
      flow_invalid <= 1'b1;
      class_format <= 1'b0;
      acc(1, 16'h3001, 0, 1, 32'h0000_0006, FOD_RSP_WRITE, 0);
      acc(0, 16'h1002, 0, 4, 0, FOD_RSP_READ, 32'h0000_0001);
      chk(last_emcy, {8'h00, 32'h0000_0001, 8'h01, 16'hFF00});
      flow_invalid <= 1'b0;
      acc(0, 16'h1002, 0, 4, 0, FOD_RSP_READ, 0);
      acc(0, 16'h1001, 0, 1, 0, FOD_RSP_READ, 0);
   endtask

   // Sets the divider, aligns on a transmission (a period end when the divider is zero), then counts periods and transmissions
   task automatic meas(input logic [15:0] div, input int nd, input int np);
      int d0;
      int p0;
      int n;
      acc(1, 16'h3003, 0, 2, {16'h0000, div}, FOD_RSP_WRITE, 0);
      // Align on a transmission, or on a period end when transmission is off
      d0 = n_done;
      p0 = n_pdo;
      for (n = 0; n < 4 * MEAS && (div != 0 ? n_pdo == p0 : n_done == d0); n++)
         @(posedge clk);
      if (n == 4 * MEAS)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         print_verdict();
      end
      d0 = n_done;
      p0 = n_pdo;
      for (n = 0; n < nd * MEAS + MEAS / 2; n++)
         @(posedge clk);
      chk(n_done - d0, nd);
      chk(n_pdo - p0, np);
      chk(last_pdo, {volume_flow, class_14um, class_6um, class_4um});
   endtask

   // Unsaved changes must vanish across a reset
   task automatic t_reset;
      acc(1, 16'h3000, 0, 1, 32'h0000_0009, FOD_RSP_WRITE, 0);
      acc(1, 16'h1012, 0, 4, 32'h0000_0123, FOD_RSP_WRITE, 0);
      chk(time_id_out, 32'h0000_0123);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      acc(0, 16'h3000, 0, 1, 0, FOD_RSP_READ, 0);
      acc(0, 16'h1012, 0, 4, 0, FOD_RSP_READ, 32'h0000_0100);
      chk(time_id_out, 32'h0000_0100);
      acc(0, 16'h3003, 0, 2, 0, FOD_RSP_READ, 32'h0000_0001);
   endtask

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      flow_invalid = 1'b0;
      class_format = 1'b0;
      class_4um = 16'h0011;
      class_6um = 16'h0012;
      class_14um = 16'h0013;
      volume_flow = 16'h0014;
      float_4um = 32'h4120_0000;
      float_6um = 32'h4110_0000;
      float_14um = 32'h4100_0000;
      float_flow = 32'h42C8_0000;
      record_count_in = 16'h0003;
      record_word = 32'h0102_0304;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_save();
      t_limits();
      meas(16'h0001, 3, 3);
      meas(16'h0002, 4, 2);
      meas(16'h0000, 3, 0);
      t_reset();
      print_verdict();
   end
endmodule
`default_nettype wire

// ==== hw/fod_consts.svh ====
// Constants of the fieldbus object dictionary: indices, abort codes, reset values, timing.
// Assumes inclusion by bare name from the package and the dictionary module.
`ifndef FOD_CONSTS_SVH
`define FOD_CONSTS_SVH
`define FOD_IDX_PROFILE 16'h1000
`define FOD_IDX_GENERR 16'h1001
`define FOD_IDX_FAULT 16'h1002
`define FOD_IDX_GUARD 16'h100C
`define FOD_IDX_LIFE 16'h100D
`define FOD_IDX_SAVE 16'h1010
`define FOD_IDX_TIME_ID 16'h1012
`define FOD_IDX_EMCY_ID 16'h1014
`define FOD_IDX_HEARTBEAT 16'h1017
`define FOD_IDX_SDO_PAR 16'h1200
`define FOD_IDX_TPDO_COMM 16'h1800
`define FOD_IDX_TPDO_MAP 16'h1A00
`define FOD_IDX_LIMIT_4 16'h3000
`define FOD_IDX_LIMIT_6 16'h3001
`define FOD_IDX_LIMIT_14 16'h3002
`define FOD_IDX_DIVIDER 16'h3003
`define FOD_IDX_STORE_INT 16'h4000
`define FOD_IDX_REC_COUNT 16'h4001
`define FOD_IDX_REC_FIRST 16'h4002
`define FOD_IDX_REC_LAST 16'h43E9
`define FOD_IDX_PV_INT 16'h5000
`define FOD_IDX_PV_FLOAT 16'h5100
`define FOD_SAVE_SIG 32'h6576_6173
`define FOD_SAVE_MODE 32'h0000_0001
`define FOD_TIME_ID_RST 32'h0000_0100
`define FOD_EMCY_BASE 32'h0000_0080
`define FOD_RX_BASE 32'h0000_0600
`define FOD_TX_BASE 32'h0000_0580
`define FOD_TPDO_BASE 32'h0000_0180
`define FOD_TX_TYPE 32'h0000_00FE
`define FOD_MAP_BASE 32'h5000_0010
`define FOD_DIVIDER_RST 16'h0001
`define FOD_ABORT_ACCESS 32'h0601_0000
`define FOD_ABORT_NOOBJ 32'h0602_0000
`define FOD_ABORT_READONLY 32'h0601_0002
`define FOD_GENERR_BIT 0
`define FOD_FLT_FLOW 0
`define FOD_FLT_14 1
`define FOD_FLT_6 2
`define FOD_FLT_4 3
`define FOD_MEAS_TIME_S 20
`define FOD_CLK_HZ 20000000
`endif

// ==== hw/fod_dictionary.sv ====
// Object dictionary of a contamination transmitter on a fieldbus.
// Assumes a service-data framer outside that presents decoded requests as one-cycle strobes
// on clk, and a measurement engine on the same clock supplying classes, flow and faults.
//
// What this block does
// - Every parameter and value reachable by index
// - Entries addressed by 16-bit index, 8-bit subindex
// - Error bit 0 set on fault or limit
// - Emergency carries general error entry
// - Fault word follows live fault conditions
// - Bits: flow, 14, 6, 4 micron
// - Limit bits only in class report format
// - Fault bits 4 to 31 unused
// - Emergency carries full fault status word
// - Emergency: code, error, status, unused byte
// - Save entry subindex 1 reads one
// - Unsaved changes lost at reset
// - Write "save" signature pulses save_request
// - Three 8-bit class limits compared
// - Zero limit disables its monitoring
// - Process message every N measurements
// - Twenty second cycle advances counter
// - Divider one sends every measurement; reset one
// - Divider zero suppresses transmission
// - Process values: 4, 6, 14 classes, flow
`include "fod_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fod_dictionary
   import fod_pkg::*;
#(
   parameter int unsigned MEAS_CYCLES = `FOD_MEAS_TIME_S * `FOD_CLK_HZ,
   parameter logic [6:0] NODE_ID = 7'h01,
   parameter logic [31:0] PROFILE_CODE = 32'h0000_0A5A // Arbitrary value
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_index,
   input wire logic [7:0] req_subindex,
   input wire logic [2:0] req_size,
   input wire logic [31:0] req_data,
   output logic rsp_valid,
   output fod_rsp_t rsp_kind,
   output logic [31:0] rsp_data,
   input wire logic [15:0] class_4um,
   input wire logic [15:0] class_6um,
   input wire logic [15:0] class_14um,
   input wire logic [15:0] volume_flow,
   input wire logic [31:0] float_4um,
   input wire logic [31:0] float_6um,
   input wire logic [31:0] float_14um,
   input wire logic [31:0] float_flow,
   input wire logic flow_invalid,
   input wire logic class_format,
   input wire logic [15:0] record_count_in,
   input wire logic [31:0] record_word,
   output logic records_clear,
   output logic save_request,
   output logic [7:0] limit_4um_out,
   output logic [7:0] limit_6um_out,
   output logic [7:0] limit_14um_out,
   output logic [15:0] storage_interval_out,
   output logic [31:0] time_id_out,
   output logic [15:0] heartbeat_out,
   output logic measure_done,
   output logic pdo_send,
   output logic [63:0] pdo_payload,
   output logic emcy_send,
   output logic [63:0] emcy_payload
);
   logic rst_meta;
   logic rst_n;
   logic [31:0] time_message_identifier;
   logic [15:0] heartbeat_period;
   logic [7:0] limit_4um;
   logic [7:0] limit_6um;
   logic [7:0] limit_14um;
   logic [15:0] transmit_divider;
   logic [15:0] storage_interval_hours;
   logic [31:0] fault_status_word;
   logic [31:0] next_fault;
   logic [7:0] general_error_flag;
   logic [31:0] meas_timer;
   logic [15:0] meas_count;
   logic [31:0] rd_value;
   logic rd_ok;
   logic wr_ok;
   logic is_write;
   logic [31:0] abort_code;
   logic [31:0] node32;

   assign node32 = {25'h000_0000, NODE_ID};
   assign is_write = req_valid && req_write;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Live fault word, recomputed every cycle from current conditions
   always_comb
   begin
      next_fault = 32'h0000_0000;
      next_fault[`FOD_FLT_FLOW] = flow_invalid;
      next_fault[`FOD_FLT_4] = class_format && (limit_4um != 8'h00) && (class_4um > {8'h00, limit_4um});
      next_fault[`FOD_FLT_6] = class_format && (limit_6um != 8'h00) && (class_6um > {8'h00, limit_6um});
      next_fault[`FOD_FLT_14] = class_format && (limit_14um != 8'h00)
         && (class_14um > {8'h00, limit_14um});
   end

   // Fault word and general error flag; error follows any active fault
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_status_word <= 32'h0000_0000;
         general_error_flag <= 8'h00;
      end
      else
      begin
         fault_status_word <= next_fault;
         general_error_flag <= {7'h00, |next_fault};
      end
   end

   // Emergency in each cycle that newly raises any fault bit; a clearing fault sends nothing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         emcy_send <= 1'b0;
         emcy_payload <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         emcy_send <= |(next_fault & ~fault_status_word);
         // Byte order: code (lsb first), error flag, status word, unused
         emcy_payload <= {8'h00, next_fault, 7'h00, |next_fault, 16'hFF00};
      end
   end

   // Writable entries; these are volatile and revert at every reset, saved or not; a save only pulses save_request
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         time_message_identifier <= `FOD_TIME_ID_RST;
         heartbeat_period <= 16'h0000;
         limit_4um <= 8'h00;
         limit_6um <= 8'h00;
         limit_14um <= 8'h00;
         transmit_divider <= `FOD_DIVIDER_RST;
         storage_interval_hours <= 16'h0000;
      end
      else if (is_write && wr_ok && req_subindex == 8'h00)
      begin
         unique case (req_index)
            `FOD_IDX_TIME_ID: time_message_identifier <= req_data;
            `FOD_IDX_HEARTBEAT: heartbeat_period <= req_data[15:0];
            `FOD_IDX_LIMIT_4: limit_4um <= req_data[7:0];
            `FOD_IDX_LIMIT_6: limit_6um <= req_data[7:0];
            `FOD_IDX_LIMIT_14: limit_14um <= req_data[7:0];
            `FOD_IDX_DIVIDER: transmit_divider <= req_data[15:0];
            `FOD_IDX_STORE_INT: storage_interval_hours <= req_data[15:0];
            default: ;
         endcase
      end
   end

   // Write decode: which writes are legal
   always_comb
   begin
      wr_ok = 1'b0;
      if (req_subindex == 8'h00)
      begin
         unique case (req_index)
            `FOD_IDX_TIME_ID, `FOD_IDX_HEARTBEAT, `FOD_IDX_LIMIT_4, `FOD_IDX_LIMIT_6,
            `FOD_IDX_LIMIT_14, `FOD_IDX_DIVIDER, `FOD_IDX_STORE_INT: wr_ok = 1'b1;
            `FOD_IDX_REC_COUNT: wr_ok = (req_data == 32'h0000_0000);
            default: wr_ok = 1'b0;
         endcase
      end
      else if (req_index == `FOD_IDX_SAVE && req_subindex == 8'h01)
      begin
         wr_ok = (req_size == 3'd4) && (req_data == `FOD_SAVE_SIG);
      end
   end

   // Read decode by index and subindex
   always_comb
   begin
      rd_ok = 1'b1;
      rd_value = 32'h0000_0000;
      if (req_index >= `FOD_IDX_REC_FIRST && req_index <= `FOD_IDX_REC_LAST)
      begin
         // Record words come from the external store; missing sets are refused
         rd_ok = (req_index - `FOD_IDX_REC_FIRST) < record_count_in;
         rd_value = (req_subindex == 8'h00) ? 32'h0000_0009 : record_word;
      end
      else
      begin
         unique case ({req_index, req_subindex})
            {`FOD_IDX_PROFILE, 8'h00}: rd_value = PROFILE_CODE;
            {`FOD_IDX_GENERR, 8'h00}: rd_value = {24'h00_0000, general_error_flag};
            {`FOD_IDX_FAULT, 8'h00}: rd_value = fault_status_word;
            {`FOD_IDX_GUARD, 8'h00}: rd_value = 32'h0000_0000;
            {`FOD_IDX_LIFE, 8'h00}: rd_value = 32'h0000_0000;
            {`FOD_IDX_SAVE, 8'h00}: rd_value = 32'h0000_0001;
            {`FOD_IDX_SAVE, 8'h01}: rd_value = `FOD_SAVE_MODE;
            {`FOD_IDX_TIME_ID, 8'h00}: rd_value = time_message_identifier;
            {`FOD_IDX_EMCY_ID, 8'h00}: rd_value = `FOD_EMCY_BASE + node32;
            {`FOD_IDX_HEARTBEAT, 8'h00}: rd_value = {16'h0000, heartbeat_period};
            {`FOD_IDX_SDO_PAR, 8'h00}: rd_value = 32'h0000_0002;
            {`FOD_IDX_SDO_PAR, 8'h01}: rd_value = `FOD_RX_BASE + node32;
            {`FOD_IDX_SDO_PAR, 8'h02}: rd_value = `FOD_TX_BASE + node32;
            {`FOD_IDX_TPDO_COMM, 8'h00}: rd_value = 32'h0000_0002;
            {`FOD_IDX_TPDO_COMM, 8'h01}: rd_value = `FOD_TPDO_BASE + node32;
            {`FOD_IDX_TPDO_COMM, 8'h02}: rd_value = `FOD_TX_TYPE;
            {`FOD_IDX_TPDO_MAP, 8'h00}: rd_value = 32'h0000_0004;
            {`FOD_IDX_LIMIT_4, 8'h00}: rd_value = {24'h00_0000, limit_4um};
            {`FOD_IDX_LIMIT_6, 8'h00}: rd_value = {24'h00_0000, limit_6um};
            {`FOD_IDX_LIMIT_14, 8'h00}: rd_value = {24'h00_0000, limit_14um};
            {`FOD_IDX_DIVIDER, 8'h00}: rd_value = {16'h0000, transmit_divider};
            {`FOD_IDX_STORE_INT, 8'h00}: rd_value = {16'h0000, storage_interval_hours};
            {`FOD_IDX_REC_COUNT, 8'h00}: rd_value = {16'h0000, record_count_in};
            {`FOD_IDX_PV_INT, 8'h00}: rd_value = 32'h0000_0004;
            {`FOD_IDX_PV_INT, 8'h01}: rd_value = {16'h0000, class_4um};
            {`FOD_IDX_PV_INT, 8'h02}: rd_value = {16'h0000, class_6um};
            {`FOD_IDX_PV_INT, 8'h03}: rd_value = {16'h0000, class_14um};
            {`FOD_IDX_PV_INT, 8'h04}: rd_value = {16'h0000, volume_flow};
            {`FOD_IDX_PV_FLOAT, 8'h00}: rd_value = 32'h0000_0004;
            {`FOD_IDX_PV_FLOAT, 8'h01}: rd_value = float_4um;
            {`FOD_IDX_PV_FLOAT, 8'h02}: rd_value = float_6um;
            {`FOD_IDX_PV_FLOAT, 8'h03}: rd_value = float_14um;
            {`FOD_IDX_PV_FLOAT, 8'h04}: rd_value = float_flow;
            default:
               // Mapping entries 1..4 name the four process values in order
               if (req_index == `FOD_IDX_TPDO_MAP && req_subindex >= 8'h01 && req_subindex <= 8'h04)
                  rd_value = `FOD_MAP_BASE + {16'h0000, req_subindex, 8'h00};
               else
                  rd_ok = 1'b0;
         endcase
      end
   end

   // Abort code: a readable object that is written is read-only; a missing record read is an access fault, written is no object
   assign abort_code = is_write ? (rd_ok ? `FOD_ABORT_READONLY : `FOD_ABORT_NOOBJ)
      : ((req_index >= `FOD_IDX_REC_FIRST && req_index <= `FOD_IDX_REC_LAST) ? `FOD_ABORT_ACCESS : `FOD_ABORT_NOOBJ);

   // Response, one cycle after each request; kind and data hold until the next request
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_kind <= FOD_RSP_READ;
         rsp_data <= 32'h0000_0000;
         save_request <= 1'b0;
         records_clear <= 1'b0;
      end
      else
      begin
         rsp_valid <= req_valid;
         save_request <= is_write && wr_ok && req_index == `FOD_IDX_SAVE;
         records_clear <= is_write && wr_ok && req_index == `FOD_IDX_REC_COUNT;
         if (is_write)
         begin
            rsp_kind <= wr_ok ? FOD_RSP_WRITE : FOD_RSP_ABORT;
            rsp_data <= wr_ok ? 32'h0000_0000 : abort_code;
         end
         else if (req_valid)
         begin
            rsp_kind <= rd_ok ? FOD_RSP_READ : FOD_RSP_ABORT;
            rsp_data <= rd_ok ? rd_value : abort_code;
         end
      end
   end

   // Measurement period and transmit divider
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meas_timer <= 32'h0000_0000;
         meas_count <= 16'h0000;
         measure_done <= 1'b0;
         pdo_send <= 1'b0;
      end
      else
      begin
         measure_done <= 1'b0;
         pdo_send <= 1'b0;
         if (meas_timer == MEAS_CYCLES - 1)
         begin
            meas_timer <= 32'h0000_0000;
            measure_done <= 1'b1;
            if (transmit_divider == 16'h0000)
               meas_count <= 16'h0000;
            else if (meas_count + 16'h0001 >= transmit_divider)
            begin
               meas_count <= 16'h0000;
               pdo_send <= 1'b1;
            end
            else
               meas_count <= meas_count + 16'h0001;
         end
         else
            meas_timer <= meas_timer + 32'h0000_0001;
      end
   end

   // Payload and configuration outputs registered
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pdo_payload <= 64'h0000_0000_0000_0000;
         limit_4um_out <= 8'h00;
         limit_6um_out <= 8'h00;
         limit_14um_out <= 8'h00;
         storage_interval_out <= 16'h0000;
         time_id_out <= `FOD_TIME_ID_RST;
         heartbeat_out <= 16'h0000;
      end
      else
      begin
         pdo_payload <= {volume_flow, class_14um, class_6um, class_4um};
         limit_4um_out <= limit_4um;
         limit_6um_out <= limit_6um;
         limit_14um_out <= limit_14um;
         storage_interval_out <= storage_interval_hours;
         time_id_out <= time_message_identifier;
         heartbeat_out <= heartbeat_period;
      end
   end

   // A request is answered on the very next edge
   a_rsp_follows: assert property (@(posedge clk) disable iff (!rst_n)
      req_valid |=> rsp_valid) else $error("response missing");
   a_error_tracks: assert property (@(posedge clk) disable iff (!rst_n)
      general_error_flag[0] == (fault_status_word != 32'h0000_0000)) else $error("error flag wrong");
   a_error_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (next_fault == 32'h0000_0000) |=> !general_error_flag[0]) else $error("error not cleared");
   a_unused_bits: assert property (@(posedge clk) disable iff (!rst_n)
      fault_status_word[31:4] == 28'h000_0000) else $error("unused fault bits set");
   a_limit_off: assert property (@(posedge clk) disable iff (!rst_n)
      (limit_4um == 8'h00 || !class_format) |=> !fault_status_word[`FOD_FLT_4]) else $error("limit off yet set");
   a_emcy_content: assert property (@(posedge clk) disable iff (!rst_n)
      emcy_send |-> emcy_payload[55:24] == fault_status_word && emcy_payload[23:16] == general_error_flag)
      else $error("emergency content wrong");
   a_save_read: assert property (@(posedge clk) disable iff (!rst_n)
      (req_valid && !req_write && req_index == `FOD_IDX_SAVE && req_subindex == 8'h01)
      |=> rsp_data == 32'h0000_0001) else $error("save mode read wrong");
   a_divider_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (transmit_divider == 16'h0000) |=> !pdo_send) else $error("send with divider zero");
endmodule
`default_nettype wire

// ==== hw/fod_pkg.sv ====
// Types shared by the fieldbus object dictionary.
// Assumes fod_consts.svh is on the include path.
`include "fod_consts.svh"
package fod_pkg;
   typedef enum logic [1:0] {
      FOD_RSP_READ,
      FOD_RSP_WRITE,
      FOD_RSP_ABORT
   } fod_rsp_t;
endpackage
